/* logic/sbt_pkg.sv */
// package for the split byte timer: register map, fields, reset values
// assumes a 32-bit axi4-lite slave and a single 200 MHz clock
package sbt_pkg;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] SBT_CTRL = 8'h00;
	localparam logic [7:0] SBT_EVCTRL = 8'h04;
	localparam logic [7:0] SBT_INTEN = 8'h08;
	localparam logic [7:0] SBT_FLAGS = 8'h0C;
	localparam logic [7:0] SBT_CNT = 8'h10;
	localparam logic [7:0] SBT_PER = 8'h14;
	localparam logic [7:0] SBT_CMP_LO = 8'h18;
	localparam logic [7:0] SBT_CMP_HI = 8'h1C;

	// ==========================================================
	// field positions
	localparam int SBT_CTRL_SPLIT = 0;
	localparam int SBT_CTRL_CLKSEL_LSB = 1;
	localparam int SBT_CTRL_PRESC_LSB = 4;
	localparam int SBT_CTRL_OUTEN_LSB = 8;
	localparam int SBT_EV_GATE = 0;
	localparam int SBT_FLAG_UNF_LO = 0;
	localparam int SBT_FLAG_UNF_HI = 1;
	localparam int SBT_FLAG_CMP_LSB = 2;

	// ==========================================================
	// reset values
	localparam logic [7:0] SBT_PER_RESET = 8'hFF;
	localparam logic [7:0] SBT_CMP_RESET = 8'h00;
	localparam logic [7:0] SBT_CNT_RESET = 8'hFF;

	// ==========================================================
	// clock source selection
	typedef enum logic [2:0] {
		SBT_SRC_OFF = 3'h0,
		SBT_SRC_PER = 3'h1,
		SBT_SRC_PRESC = 3'h2,
		SBT_SRC_EVENT = 3'h3
	} sbt_src_t;

	typedef struct packed {
		logic [7:0] lo;
		logic [7:0] hi;
	} sbt_pair_t;

	typedef struct packed {
		logic [3:0] cmp_lo;
		logic unf_hi;
		logic unf_lo;
	} sbt_evt_t;

endpackage

/* logic/sbt_prescaler.sv */
// prescaler: divides the peripheral clock into one-cycle enable pulses
// assumes a single clock; the ratio is 2 to the power of sel, capped at 2 to the power of WIDTH
module sbt_prescaler
	import sbt_pkg::*;
#(
	parameter int WIDTH = 10
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// control
	input wire logic run,
	input wire logic [3:0] sel,
	// enable out
	output logic tick
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] mask;

	always_comb begin
		mask = WIDTH'((32'h1 << sel) - 32'h1);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !run) begin
			count <= '0;
			tick <= 1'b0;
		end else begin
			count <= count + WIDTH'(1);
			tick <= ((count & mask) == mask);
		end
	end

endmodule // sbt_prescaler

/* logic/sbt_timer.sv */
// split byte timer: two 8-bit down counters, eight single-slope pwm pins
// assumes an axi4-lite master and a single clock; events come in synchronous
module sbt_timer
	import sbt_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// event system
	input wire logic count_event,
	output sbt_evt_t event_out,
	// pwm pins and interrupt requests
	output logic [7:0] pwm_out,
	output logic irq_unf_lo,
	output logic irq_unf_hi,
	output logic [3:0] irq_cmp
);

	// ==========================================================
	// registers
	logic split_en;
	sbt_src_t clk_src;
	logic [3:0] presc_sel;
	logic [7:0] out_en;
	logic ev_gate;
	logic [5:0] int_en;
	logic [5:0] flags;
	sbt_pair_t cnt;
	sbt_pair_t per;
	logic [7:0] cmp [8];
	logic presc_tick;
	logic tick;
	logic [5:0] hw_set;
	logic [5:0] sw_clr;

	function automatic logic [7:0] merge(input logic [7:0] old,
		input logic [31:0] data, input logic [3:0] strb, input int lane);
		merge = strb[lane] ? data[lane*8 +: 8] : old;
	endfunction

	// ==========================================================
	// count tick source
	sbt_prescaler #(.WIDTH(16)) u_presc (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(split_en && clk_src == SBT_SRC_PRESC),
		.sel(presc_sel),
		.tick(presc_tick)
	);

	always_comb begin
		case (clk_src)
			SBT_SRC_PER: tick = 1'b1;
			SBT_SRC_PRESC: tick = presc_tick;
			SBT_SRC_EVENT: tick = count_event;
			default: tick = 1'b0;
		endcase
		// with the gate on, a low event input halts every source except the event source itself
		if (ev_gate && clk_src != SBT_SRC_EVENT && !count_event) begin
			tick = 1'b0;
		end
		if (!split_en) begin
			tick = 1'b0;
		end
	end

	// ==========================================================
	// byte counters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= {SBT_CNT_RESET, SBT_CNT_RESET};
		end else if (tick) begin
			// shared tick, separate periods
			cnt.lo <= (cnt.lo == 8'h00) ? per.lo : cnt.lo - 8'h01;
			cnt.hi <= (cnt.hi == 8'h00) ? per.hi : cnt.hi - 8'h01;
		end
	end

	// ==========================================================
	// compare and pwm: pin high while count is below compare
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_pwm
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pwm_out[g] <= 1'b0;
				end else begin
					pwm_out[g] <= out_en[g] && split_en &&
						(((g < 4) ? cnt.lo : cnt.hi) < cmp[g]);
				end
			end
		end
	endgenerate

	// ==========================================================
	// flags, interrupts and events
	always_comb begin
		hw_set = '0;
		hw_set[SBT_FLAG_UNF_LO] = tick && cnt.lo == 8'h00;
		hw_set[SBT_FLAG_UNF_HI] = tick && cnt.hi == 8'h00;
		for (int i = 0; i < 4; i++) begin
			// high byte matches deliberately never flagged
			hw_set[SBT_FLAG_CMP_LSB+i] = tick && cnt.lo == cmp[i];
		end
		sw_clr = '0;
		if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
			s_axi_awaddr == SBT_FLAGS && s_axi_wstrb[0]) begin
			sw_clr = s_axi_wdata[5:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= '0;
			event_out <= '0;
			irq_unf_lo <= 1'b0;
			irq_unf_hi <= 1'b0;
			irq_cmp <= '0;
		end else begin
			// set wins over a write-one clear in the same cycle
			flags <= (flags & ~sw_clr) | hw_set;
			event_out <= sbt_evt_t'(hw_set);
			irq_unf_lo <= flags[0] && int_en[0];
			irq_unf_hi <= flags[1] && int_en[1];
			irq_cmp <= flags[5:2] & int_en[5:2];
		end
	end

	// ==========================================================
	// axi4-lite write: takes address and data together, answers next cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			split_en <= 1'b0;
			clk_src <= SBT_SRC_OFF;
			presc_sel <= 4'h0;
			out_en <= 8'h00;
			ev_gate <= 1'b0;
			int_en <= '0;
			per <= {SBT_PER_RESET, SBT_PER_RESET};
			for (int i = 0; i < 8; i++) begin
				cmp[i] <= SBT_CMP_RESET;
			end
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
				!s_axi_awready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (s_axi_awaddr)
					SBT_CTRL: begin
						if (s_axi_wstrb[0]) begin
							split_en <= s_axi_wdata[SBT_CTRL_SPLIT];
							clk_src <= sbt_src_t'(
								s_axi_wdata[SBT_CTRL_CLKSEL_LSB +: 3]);
							presc_sel <= s_axi_wdata[SBT_CTRL_PRESC_LSB +: 4];
						end
						out_en <= merge(out_en, s_axi_wdata, s_axi_wstrb, 1);
					end
					SBT_EVCTRL: begin
						if (s_axi_wstrb[0]) begin
							ev_gate <= s_axi_wdata[SBT_EV_GATE];
						end
					end
					SBT_INTEN: begin
						if (s_axi_wstrb[0]) begin
							int_en <= s_axi_wdata[5:0];
						end
					end
					SBT_FLAGS: begin
					end
					SBT_PER: begin
						per.lo <= merge(per.lo, s_axi_wdata, s_axi_wstrb, 0);
						per.hi <= merge(per.hi, s_axi_wdata, s_axi_wstrb, 1);
					end
					SBT_CMP_LO: begin
						for (int i = 0; i < 4; i++) begin
							cmp[i] <= merge(cmp[i], s_axi_wdata, s_axi_wstrb, i);
						end
					end
					SBT_CMP_HI: begin
						for (int i = 0; i < 4; i++) begin
							cmp[4+i] <= merge(cmp[4+i], s_axi_wdata,
								s_axi_wstrb, i);
						end
					end
					default: s_axi_bresp <= 2'h2;
				endcase
			end
		end
	end

	// ==========================================================
	// axi4-lite read: answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				s_axi_rdata <= 32'h0;
				case (s_axi_araddr)
					SBT_CTRL: s_axi_rdata <= {16'h0, out_en, presc_sel,
						clk_src, split_en};
					SBT_EVCTRL: s_axi_rdata <= {31'h0, ev_gate};
					SBT_INTEN: s_axi_rdata <= {26'h0, int_en};
					SBT_FLAGS: s_axi_rdata <= {26'h0, flags};
					SBT_CNT: s_axi_rdata <= {16'h0, cnt.hi, cnt.lo};
					SBT_PER: s_axi_rdata <= {16'h0, per.hi, per.lo};
					SBT_CMP_LO: s_axi_rdata <= {cmp[3], cmp[2], cmp[1], cmp[0]};
					SBT_CMP_HI: s_axi_rdata <= {cmp[7], cmp[6], cmp[5], cmp[4]};
					default: s_axi_rresp <= 2'h2;
				endcase
			end
		end
	end

endmodule // sbt_timer

/* test/sbt_timer_assertions.sv */
// checker for the split byte timer register bus handshakes
// assumes sbt_timer ports, one clock, synchronous low reset
module sbt_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write side
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read side
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// request taken
	sequence s_aw_take;
		s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
	endsequence
	sequence s_ar_take;
		s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
	endsequence
	a_write_answer: assert property (s_aw_take |=>
		s_axi_awready && s_axi_wready && s_axi_bvalid)
		else $error("write not answered next cycle");
	a_write_bad_addr: assert property (s_aw_take ##0 (s_axi_awaddr > 8'h1C)
		|=> s_axi_bresp == 2'h2) else $error("unmapped write not refused");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready longer than one cycle");
	a_read_answer: assert property (s_ar_take |=>
		s_axi_arready && s_axi_rvalid) else $error("read not answered");
	a_read_bad_addr: assert property (s_ar_take ##0 (s_axi_araddr > 8'h1C)
		|=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("arready longer than one cycle");
endmodule // sbt_chk

bind sbt_timer sbt_chk u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

/* test/test_split_dual_byte_pwm_timer.sv */
// self-checking bench for the split byte timer
// assumes sbt_pkg and sbt_timer compiled first
module test_split_dual_byte_pwm_timer
	import sbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0] r;
	} sbt_row_t;
	logic aclk = 1'h0, aresetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, e;
	logic [3:0] s_axi_wstrb = 4'hF, irq_cmp;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, count_event = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq_unf_lo, irq_unf_hi;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] pwm_out;
	sbt_evt_t event_out;
	int err_count = 0, comparisons = 0, n;
	int cnt[6];
	int exp_cnt[6] = '{3, 2, 3, 6, 8, 0};
	sbt_row_t rows[6] = '{'{SBT_PER, 32'h503, 32'h503, 2'h0},
		'{SBT_CMP_LO, 32'h2, 32'h2, 2'h0}, '{SBT_CMP_HI, 32'h4, 32'h4, 2'h0},
		'{SBT_INTEN, 32'h3F, 32'h3F, 2'h0}, '{8'h20, 32'h1, 32'h0, 2'h2},
		'{SBT_CTRL, 32'hFF03, 32'hFF03, 2'h0}};

	sbt_timer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_event,
		.event_out, .pwm_out, .irq_unf_lo, .irq_unf_hi, .irq_cmp);

	// ==========================================================
	// bus tasks
	task automatic chk(input string nm, input logic [31:0] x, y);
		comparisons++;
		if (y !== x) begin
			$display("[ERR] %s expected %h seen %h", nm, x, y);
			err_count++;
		end
	endtask
	// bready raised late on purpose, so the slave must hold bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] rs);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		do @(posedge aclk); while (s_axi_awready !== 1'h1);
		s_axi_awvalid <= 1'h0;
		s_axi_wvalid <= 1'h0;
		s_axi_bready <= 1'h1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do @(posedge aclk); while (s_axi_arready !== 1'h1);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic wrap_up;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// clock, watchdog, tests
	initial begin
		forever #2.5 aclk = ~aclk;
	end
	initial begin
		#20000;
		err_count++;
		wrap_up;
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, r);
			chk("bresp", 32'(rows[i].r), 32'(r));
			rd(rows[i].a, d, r);
			chk("rdata", rows[i].e, d);
			chk("rresp", 32'(rows[i].r), 32'(r));
		end
		// counters start at 0xFF, so the first underflow comes late
		n = 0;
		while (event_out.unf_lo !== 1'h1 && n < 400) begin
			@(posedge aclk);
			n++;
		end
		cnt = '{0, 0, 0, 0, 0, 0};
		repeat (12) begin
			@(posedge aclk);
			cnt[0] += int'(event_out.unf_lo === 1'h1);
			cnt[1] += int'(event_out.unf_hi === 1'h1);
			cnt[2] += int'(event_out.cmp_lo[0] === 1'h1);
			cnt[3] += int'(pwm_out[0] === 1'h1);
			cnt[4] += int'(pwm_out[4] === 1'h1);
			cnt[5] += int'(pwm_out[1] === 1'h1);
		end
		foreach (cnt[i]) chk("window", exp_cnt[i], cnt[i]);
		chk("irq", 32'h3F, 32'({irq_cmp, irq_unf_hi, irq_unf_lo}));
		// event source: counting only on sampled event level
		wr(SBT_CTRL, 32'hFF07, r);
		rd(SBT_CNT, d, r);
		repeat (20) @(posedge aclk);
		rd(SBT_CNT, e, r);
		chk("cnt frozen", d, e);
		count_event <= 1'h1;
		repeat (2) @(posedge aclk);
		count_event <= 1'h0;
		rd(SBT_CNT, e, r);
		n = (int'(d[15:8]) + 4) % 6 * 256 + (int'(d[7:0]) + 2) % 4;
		chk("cnt step", 32'(n), e);
		// prescaled source, one tick every 4 cycles: 10 ticks in 41 edges
		wr(SBT_CTRL, 32'hFF25, r);
		rd(SBT_CNT, d, r);
		repeat (38) @(posedge aclk);
		rd(SBT_CNT, e, r);
		n = (int'(d[15:8]) + 2) % 6 * 256 + (int'(d[7:0]) + 2) % 4;
		chk("cnt presc", 32'(n), e);
		// gate closed while event input is low
		wr(SBT_EVCTRL, 32'h1, r);
		wr(SBT_CTRL, 32'hFF03, r);
		rd(SBT_CNT, d, r);
		repeat (10) @(posedge aclk);
		rd(SBT_CNT, e, r);
		chk("cnt gated", d, e);
		// timer off, then write-one clear of every flag
		wr(SBT_CTRL, 32'h0, r);
		wr(SBT_FLAGS, 32'h3F, r);
		rd(SBT_FLAGS, d, r);
		chk("flags clr", 32'h0, d);
		// reset in mid-run
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		chk("pwm reset", 32'h0, 32'(pwm_out));
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(SBT_CNT, d, r);
		chk("cnt reset", 32'h0000FFFF, d);
		rd(SBT_PER, d, r);
		chk("per reset", 32'h0000FFFF, d);
		wrap_up;
	end
endmodule // test_split_dual_byte_pwm_timer
